// >>> hdl/smr_regs.svh
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define SMR_SETUP_OFS 12'h500
`define SMR_CTRL_OFS 12'h504
`define SMR_WDATA_OFS 12'h508
`define SMR_RDATA_OFS 12'h50C

// ************************************************************
// Field positions
// ************************************************************
`define SMR_EN_BIT 6
`define SMR_DIV_MSB 5
`define SMR_DIV_LSB 0
`define SMR_PHY_MSB 28
`define SMR_PHY_LSB 24
`define SMR_REG_MSB 20
`define SMR_REG_LSB 16
`define SMR_OP_MSB 15
`define SMR_OP_LSB 14
`define SMR_START_BIT 11
`define SMR_READY_BIT 7
`define SMR_RDREADY_BIT 16
`define SMR_DATA_MSB 15

// ************************************************************
// Reset values and codes
// ************************************************************
`define SMR_EN_RST 1'h0
`define SMR_DIV_RST 6'h00
`define SMR_ADDR_RST 5'h00
`define SMR_OP_RST 2'h0
`define SMR_DATA_RST 16'h0000
`define SMR_OP_WRITE 2'h1
`define SMR_OP_READ 2'h2
`define SMR_FRAME_START 2'h1
`define SMR_PREAMBLE 32'hFFFFFFFF
`define SMR_TA_WRITE 2'h2

// ************************************************************
// Frame timing in bit slots
// ************************************************************
`define SMR_LAST_BIT 6'h3F
`define SMR_TA_BIT 6'h2E
`define SMR_DATA_BIT 6'h30
`endif

// >>> hdl/smr_pkg.sv
package smr_pkg;
  typedef enum logic {ENG_IDLE, ENG_RUN} smr_eng_t;
  typedef logic [1:0] smr_op_t;
  typedef logic [4:0] smr_addr_t;
  typedef logic [15:0] smr_data_t;
  typedef logic [5:0] smr_div_t;
endpackage

// >>> hdl/smr_serial_engine.sv
`timescale 1ns/10ps
`include "smr_regs.svh"
module smr_serial_engine (
  input wire logic linkClk,
  input wire logic resetn,
  input wire logic enableIn,
  input wire smr_pkg::smr_div_t divisorIn,
  input wire logic startTglIn,
  input wire smr_pkg::smr_op_t opIn,
  input wire smr_pkg::smr_addr_t phyIn,
  input wire smr_pkg::smr_addr_t regIn,
  input wire smr_pkg::smr_data_t wdataIn,
  input wire logic mdioIn,
  output logic doneTgl_q,
  output smr_pkg::smr_data_t readData_q,
  output logic mdc_q,
  output logic mdioOut_q,
  output logic mdioOe_q
);
  import smr_pkg::*;

  logic rstS1_q, rstS2_q, enS1_q, enS2_q, stS1_q, stS2_q, stS3_q, miS1_q, miS2_q;
  smr_div_t divS1_q, divS2_q, half_q;
  smr_eng_t state_q;
  logic [5:0] bit_q;
  logic [63:0] shift_q;
  logic isRead_q;
  logic startEdge;

  // ************************************************************
  // Crossings into the link domain
  // ************************************************************
  always_ff @(posedge linkClk) begin
    rstS1_q <= resetn;
    rstS2_q <= rstS1_q;
  end

  always_ff @(posedge linkClk) begin
    if (!rstS2_q) begin
      enS1_q <= 1'h0;
      enS2_q <= 1'h0;
      divS1_q <= `SMR_DIV_RST;
      divS2_q <= `SMR_DIV_RST;
      stS1_q <= 1'h0;
      stS2_q <= 1'h0;
      stS3_q <= 1'h0;
      miS1_q <= 1'h1;
      miS2_q <= 1'h1;
    end else begin
      enS1_q <= enableIn;
      enS2_q <= enS1_q;
      divS1_q <= divisorIn;
      divS2_q <= divS1_q;
      stS1_q <= startTglIn;
      stS2_q <= stS1_q;
      stS3_q <= stS2_q;
      miS1_q <= mdioIn;
      miS2_q <= miS1_q;
    end
  end

  assign startEdge = stS2_q ^ stS3_q;

  // ************************************************************
  // Frame sequencer
  // ************************************************************
  always_ff @(posedge linkClk) begin
    if (!rstS2_q) begin
      state_q <= ENG_IDLE;
      half_q <= `SMR_DIV_RST;
      bit_q <= 6'h00;
      shift_q <= 64'h0;
      isRead_q <= 1'h0;
      mdc_q <= 1'h0;
      mdioOut_q <= 1'h1;
      mdioOe_q <= 1'h0;
      doneTgl_q <= 1'h0;
      readData_q <= `SMR_DATA_RST;
    end else if (!enS2_q) begin
      if (state_q == ENG_RUN) begin
        doneTgl_q <= ~doneTgl_q;
      end
      state_q <= ENG_IDLE;
      mdc_q <= 1'h0;
      mdioOe_q <= 1'h0;
      mdioOut_q <= 1'h1;
    end else if (state_q == ENG_IDLE) begin
      if (startEdge) begin
        state_q <= ENG_RUN;
        half_q <= `SMR_DIV_RST;
        bit_q <= 6'h00;
        isRead_q <= (opIn == `SMR_OP_READ);
        shift_q <= {`SMR_PREAMBLE, `SMR_FRAME_START, opIn, phyIn, regIn,
                    `SMR_TA_WRITE, wdataIn};
        mdioOut_q <= 1'h1;
        mdioOe_q <= 1'h1;
      end
    end else if (half_q == divS2_q) begin
      half_q <= `SMR_DIV_RST;
      mdc_q <= ~mdc_q;
      // Sampled at the end of the bit, clear of the two pin synchroniser stages
      if (mdc_q && isRead_q && bit_q >= `SMR_DATA_BIT) begin
        readData_q <= {readData_q[14:0], miS2_q};
      end
      if (mdc_q && bit_q == `SMR_LAST_BIT) begin
        state_q <= ENG_IDLE;
        doneTgl_q <= ~doneTgl_q;
        mdioOe_q <= 1'h0;
        mdioOut_q <= 1'h1;
      end else if (mdc_q) begin
        bit_q <= bit_q + 6'h01;
        shift_q <= {shift_q[62:0], 1'h0};
        mdioOut_q <= shift_q[62];
        mdioOe_q <= !(isRead_q && bit_q + 6'h01 >= `SMR_TA_BIT);
      end
    end else begin
      half_q <= half_q + 6'h01;
    end
  end

  idle_when_off_a: assert property (@(posedge linkClk) disable iff (!rstS2_q)
    !enS2_q |=> !mdc_q && !mdioOe_q)
    else $error("serial outputs active while disabled");

  idle_lines_a: assert property (@(posedge linkClk) disable iff (!rstS2_q)
    state_q == ENG_IDLE |-> !mdioOe_q && !mdc_q)
    else $error("serial lines active outside a frame");

  read_release_a: assert property (@(posedge linkClk) disable iff (!rstS2_q)
    state_q == ENG_RUN && isRead_q && bit_q >= `SMR_TA_BIT |-> !mdioOe_q)
    else $error("data line driven during read answer");
endmodule

// >>> hdl/smr_mgmt_regs.sv
`timescale 1ns/10ps
`include "smr_regs.svh"
module smr_mgmt_regs #(
  parameter int HAS_MGMT = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic regReq,
  input wire logic regWr,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic regAck_q,
  output logic [31:0] regRdata_q,
  output logic doneIrq_q,
  output logic mdc_q,
  input wire logic mdioIn,
  output logic mdioOut_q,
  output logic mdioOe_q
);
  import smr_pkg::*;

  // ************************************************************
  // Build check
  // ************************************************************
  if (HAS_MGMT != 0 && HAS_MGMT != 1) begin : g_bad_build
    $error("HAS_MGMT must be 0 or 1");
  end

  localparam logic BUILT = (HAS_MGMT == 1);

  logic enable_q;
  smr_div_t divisor_q;
  smr_addr_t phy_q, regNum_q;
  smr_op_t op_q;
  smr_data_t wdata_q, readVal_q;
  logic busy_q, startTgl_q;
  logic dnS1_q, dnS2_q, dnS3_q;
  logic ready;
  logic doneSeen;
  logic wrSetup, wrCtrl, wrData, startReq, startOk;
  logic engDoneTgl, engMdc, engOut, engOe;
  smr_data_t engRead;

  // ************************************************************
  // Address decode
  // ************************************************************
  assign wrSetup = BUILT && regReq && regWr && regAddr == `SMR_SETUP_OFS;
  assign wrCtrl = BUILT && regReq && regWr && regAddr == `SMR_CTRL_OFS;
  assign wrData = BUILT && regReq && regWr && regAddr == `SMR_WDATA_OFS;
  assign startReq = wrCtrl && regWdata[`SMR_START_BIT];
  assign ready = enable_q && !busy_q;
  assign startOk = startReq && ready &&
    (regWdata[`SMR_OP_MSB:`SMR_OP_LSB] == `SMR_OP_WRITE ||
     regWdata[`SMR_OP_MSB:`SMR_OP_LSB] == `SMR_OP_READ);
  assign doneSeen = dnS2_q ^ dnS3_q;

  // ************************************************************
  // Setup word
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      divisor_q <= `SMR_DIV_RST;
    end else if (wrSetup && !busy_q) begin
      divisor_q <= regWdata[`SMR_DIV_MSB:`SMR_DIV_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      enable_q <= `SMR_EN_RST;
    end else if (wrSetup && regWdata[`SMR_DIV_MSB:`SMR_DIV_LSB] != `SMR_DIV_RST) begin
      enable_q <= regWdata[`SMR_EN_BIT];
    end
  end

  // ************************************************************
  // Control word and write data
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phy_q <= `SMR_ADDR_RST;
      regNum_q <= `SMR_ADDR_RST;
      op_q <= `SMR_OP_RST;
    end else if (wrCtrl && !busy_q) begin
      phy_q <= regWdata[`SMR_PHY_MSB:`SMR_PHY_LSB];
      regNum_q <= regWdata[`SMR_REG_MSB:`SMR_REG_LSB];
      op_q <= regWdata[`SMR_OP_MSB:`SMR_OP_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wdata_q <= `SMR_DATA_RST;
    end else if (wrData && !busy_q) begin
      wdata_q <= regWdata[`SMR_DATA_MSB:0];
    end
  end

  // ************************************************************
  // Transfer launch and completion
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'h0;
      startTgl_q <= 1'h0;
    end else if (startOk) begin
      busy_q <= 1'h1;
      startTgl_q <= ~startTgl_q;
    end else if (doneSeen) begin
      busy_q <= 1'h0;
    end
  end

  // Completion toggle back from the link domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dnS1_q <= 1'h0;
      dnS2_q <= 1'h0;
      dnS3_q <= 1'h0;
    end else begin
      dnS1_q <= engDoneTgl;
      dnS2_q <= dnS1_q;
      dnS3_q <= dnS2_q;
    end
  end

  // Engine read data is stable once its done toggle has arrived
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readVal_q <= `SMR_DATA_RST;
    end else if (doneSeen && op_q == `SMR_OP_READ) begin
      readVal_q <= engRead;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      doneIrq_q <= 1'h0;
    end else begin
      doneIrq_q <= BUILT && doneSeen;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regAck_q <= 1'h0;
      regRdata_q <= 32'h00000000;
    end else begin
      regAck_q <= regReq;
      regRdata_q <= 32'h00000000;
      if (regReq && !regWr && BUILT) begin
        case (regAddr)
          `SMR_SETUP_OFS: begin
            regRdata_q[`SMR_EN_BIT] <= enable_q;
            regRdata_q[`SMR_DIV_MSB:`SMR_DIV_LSB] <= divisor_q;
          end
          `SMR_CTRL_OFS: begin
            regRdata_q[`SMR_PHY_MSB:`SMR_PHY_LSB] <= phy_q;
            regRdata_q[`SMR_REG_MSB:`SMR_REG_LSB] <= regNum_q;
            regRdata_q[`SMR_OP_MSB:`SMR_OP_LSB] <= op_q;
            regRdata_q[`SMR_READY_BIT] <= ready;
          end
          `SMR_WDATA_OFS: begin
            regRdata_q[`SMR_DATA_MSB:0] <= wdata_q;
          end
          `SMR_RDATA_OFS: begin
            regRdata_q[`SMR_RDREADY_BIT] <= ready;
            regRdata_q[`SMR_DATA_MSB:0] <= readVal_q;
          end
          default: begin
            regRdata_q <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Serial engine on the link clock
  // ************************************************************
  smr_serial_engine u_engine (
    .linkClk(linkClk),
    .resetn(resetn),
    .enableIn(enable_q),
    .divisorIn(divisor_q),
    .startTglIn(startTgl_q),
    .opIn(op_q),
    .phyIn(phy_q),
    .regIn(regNum_q),
    .wdataIn(wdata_q),
    .mdioIn(mdioIn),
    .doneTgl_q(engDoneTgl),
    .readData_q(engRead),
    .mdc_q(engMdc),
    .mdioOut_q(engOut),
    .mdioOe_q(engOe)
  );

  // Outputs held off entirely when the interface is not built
  always_ff @(posedge linkClk) begin
    mdc_q <= BUILT && engMdc;
    mdioOut_q <= !BUILT || engOut;
    mdioOe_q <= BUILT && engOe;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  start_takes_busy_a: assert property (
    startOk |=> busy_q && !ready && startTgl_q != $past(startTgl_q))
    else $error("start did not launch a transfer");

  start_refused_a: assert property (
    startReq && !ready |=> (!busy_q || $past(busy_q)) && $stable(startTgl_q))
    else $error("start accepted while not ready");

  div_zero_hold_a: assert property (
    wrSetup && regWdata[5:0] == 6'h00 |=> $stable(enable_q))
    else $error("enable changed with zero divisor");

  enable_write_a: assert property (
    wrSetup && regWdata[5:0] != 6'h00 |=> enable_q == $past(regWdata[6]))
    else $error("enable write not applied");

  done_ready_a: assert property (
    doneSeen && !startOk |=> ready == enable_q)
    else $error("ready not restored after completion");

  read_capture_a: assert property (
    doneSeen && op_q == 2'h2 |=> readVal_q == $past(engRead))
    else $error("read data not captured at completion");

  ready_mirror_a: assert property (
    regReq && !regWr && regAddr == 12'h50C |=> regRdata_q[16] == $past(ready))
    else $error("read register ready copy wrong");

  ctrl_ready_a: assert property (
    regReq && !regWr && regAddr == 12'h504 |=> regRdata_q[7] == $past(enable_q && !busy_q))
    else $error("control ready bit wrong");

  done_irq_a: assert property (
    doneSeen |=> doneIrq_q ##1 !doneIrq_q)
    else $error("completion event not one pulse");

  phy_field_a: assert property (
    wrCtrl && !busy_q |=> phy_q == $past(regWdata[28:24]) && regNum_q == $past(regWdata[20:16]))
    else $error("address fields not loaded");

  field_lock_a: assert property (
    busy_q |=> $stable(phy_q) && $stable(regNum_q) && $stable(op_q) && $stable(wdata_q)
      && $stable(divisor_q))
    else $error("fields changed during a transfer");

  op_load_a: assert property (
    wrCtrl && !busy_q |=> op_q == $past(regWdata[15:14]))
    else $error("operation field not loaded");

  wdata_load_a: assert property (
    wrData && !busy_q |=> wdata_q == $past(regWdata[15:0]))
    else $error("write data not loaded");

  irq_from_done_a: assert property (
    doneIrq_q |-> $past(doneSeen))
    else $error("completion pulse without completion");

  ack_follows_a: assert property (
    regReq |=> regAck_q)
    else $error("access not acknowledged");

  rdata_idle_a: assert property (
    !regReq || regWr |=> regRdata_q == 32'h00000000)
    else $error("read data shown outside a read");

  write_start_c: cover property (startOk && regWdata[15:14] == 2'h1);
  read_start_c: cover property (startOk && regWdata[15:14] == 2'h2);
  read_done_c: cover property (doneSeen && op_q == 2'h2);
  abort_c: cover property (doneSeen && !enable_q);
  refused_start_c: cover property (startReq && !startOk);
endmodule

// >>> tb/smr_phy_model.sv
`timescale 1ns/10ps
module smr_phy_model (
  input wire logic mdc,
  input wire logic mdio,
  input wire logic [15:0] readValue,
  output logic drvOe,
  output logic drvOut,
  output logic [11:0] gotHead,
  output logic [15:0] gotData,
  output int frameCount
);
  int idx;
  logic prevBit;
  logic [15:0] outSh;

  initial begin
    idx = 0;
    prevBit = 1'b1;
    drvOe = 1'b0;
    drvOut = 1'b1;
    gotHead = 12'h000;
    gotData = 16'h0000;
    outSh = 16'h0000;
    frameCount = 0;
  end

  // ************************************************************
  // Frame capture on rising clock edges
  // ************************************************************
  always @(posedge mdc) begin
    prevBit <= mdio;
    if (idx == 0) begin
      if (!prevBit && mdio) begin
        idx <= 34;
      end
    end else begin
      if (idx <= 45) begin
        gotHead <= {gotHead[10:0], mdio};
      end
      if (idx >= 48) begin
        gotData <= {gotData[14:0], mdio};
      end
      if (idx == 63) begin
        frameCount <= frameCount + 1;
      end
      idx <= (idx == 63) ? 0 : idx + 1;
    end
  end

  // ************************************************************
  // Read answer, driven from the second turnaround bit through the read data phase
  // ************************************************************
  always @(negedge mdc) begin
    if (idx == 47 && gotHead[11:10] == 2'b10) begin
      drvOe <= 1'b1;
      drvOut <= 1'b0;
      outSh <= readValue;
    end else if (drvOe && idx >= 48) begin
      drvOut <= outSh[15];
      outSh <= {outSh[14:0], 1'b0};
    end else begin
      drvOe <= 1'b0;
      drvOut <= 1'b1;
    end
  end
endmodule

// >>> tb/smr_mgmt_regs_test.sv
`timescale 1ns/10ps
`include "smr_regs.svh"
module smr_mgmt_regs_test;
  logic clk, linkClk, resetn, regReq, regWr;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata_q, rv;
  logic regAck_q, doneIrq_q, mdc_q, mdioOut_q, mdioOe_q, phyOe, phyOut, mdioLine, mdcSeen;
  logic [11:0] gotHead;
  logic [15:0] gotData;
  int frameCount, errCount, checkCount, cycles;

  // Pull-up on the shared data line
  assign mdioLine = mdioOe_q ? mdioOut_q : (phyOe ? phyOut : 1'b1);

  smr_mgmt_regs smr_mgmt_regs_i (.clk(clk), .resetn(resetn), .linkClk(linkClk),
    .regReq(regReq), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
    .regAck_q(regAck_q), .regRdata_q(regRdata_q), .doneIrq_q(doneIrq_q), .mdc_q(mdc_q),
    .mdioIn(mdioLine), .mdioOut_q(mdioOut_q), .mdioOe_q(mdioOe_q));

  smr_phy_model smr_phy_model_i (.mdc(mdc_q), .mdio(mdioLine), .readValue(16'hBEEF),
    .drvOe(phyOe), .drvOut(phyOut), .gotHead(gotHead), .gotData(gotData),
    .frameCount(frameCount));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regReq <= 1'b1;
    regWr <= wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regReq <= 1'b0;
    #1;
    rv = regRdata_q;
    check({31'h0, regAck_q}, 32'h1);
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (doneIrq_q !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, doneIrq_q}, 32'h1);
  endtask

  task automatic endOfTest();
    $display("checks=%0d errors=%0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errCount++;
      endOfTest();
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    resetn = 1'b0;
    regReq = 1'b0;
    regWr = 1'b0;
    regAddr = 12'h000;
    regWdata = 32'h00000000;
    errCount = 0;
    checkCount = 0;
    cycles = 0;
    mdcSeen = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    access(1'b0, `SMR_CTRL_OFS, 32'h0);
    check(rv, 32'h00000000);
    access(1'b0, 12'h510, 32'h0);
    check(rv, 32'h00000000);
    access(1'b1, `SMR_SETUP_OFS, 32'h00000040);
    access(1'b0, `SMR_SETUP_OFS, 32'h0);
    check(rv, 32'h00000000);
    access(1'b1, `SMR_SETUP_OFS, 32'hFFFFFF41);
    access(1'b0, `SMR_SETUP_OFS, 32'h0);
    check(rv, 32'h00000041);
    access(1'b0, `SMR_CTRL_OFS, 32'h0);
    check(rv, 32'h00000080);
    access(1'b0, `SMR_RDATA_OFS, 32'h0);
    check(rv, 32'h00010000);
    access(1'b1, `SMR_WDATA_OFS, 32'h0001A5C3);
    access(1'b0, `SMR_WDATA_OFS, 32'h0);
    check(rv, 32'h0000A5C3);
    access(1'b1, `SMR_CTRL_OFS, 32'h150A4800);
    access(1'b0, `SMR_CTRL_OFS, 32'h0);
    check(rv, 32'h150A4000);
    access(1'b0, `SMR_RDATA_OFS, 32'h0);
    check(rv, 32'h00000000);
    waitDone();
    access(1'b0, `SMR_CTRL_OFS, 32'h0);
    check(rv, 32'h150A4080);
    check({20'h0, gotHead}, 32'h000006AA);
    check({16'h0, gotData}, 32'h0000A5C3);
    access(1'b1, `SMR_CTRL_OFS, 32'h031F8800);
    waitDone();
    check({20'h0, gotHead}, 32'h0000087F);
    access(1'b0, `SMR_RDATA_OFS, 32'h0);
    check(rv, 32'h0001BEEF);
    access(1'b1, `SMR_CTRL_OFS, 32'h031F0800);
    access(1'b0, `SMR_CTRL_OFS, 32'h0);
    check(rv, 32'h031F0080);
    check(frameCount, 2);
    access(1'b1, `SMR_SETUP_OFS, 32'h00000001);
    access(1'b1, `SMR_CTRL_OFS, 32'h031F4800);
    access(1'b0, `SMR_RDATA_OFS, 32'h0);
    check(rv, 32'h0000BEEF);
    repeat (300) begin
      @(posedge clk);
      mdcSeen = mdcSeen | mdc_q | mdioOe_q;
    end
    check({31'h0, mdcSeen}, 32'h0);
    check(frameCount, 2);
    endOfTest();
  end
endmodule
